// file: hw/cgs_pkg.sv
// Constants for the fast clock gear and oscillator switch control block.
// Assumes AXI4-Lite register access with 32-bit data, one register per word.
// Contract
// - Gear field selects quarter, half, full reference
// - Gear register upper bits read zero, resets zero
// - Hardware governs external enables, pins on stop
// - All three oscillators off raises clock reset
// - Slow clock selected but stopped raises reset
// - Internal reference selected but stopped raises reset
// - External reference selected but stopped raises reset
// - Fast enable without pin function raises reset
// - Stopping old oscillator mid-switch raises reset
// - Reference select picks external or internal clock
// - Reference switch completes within bounded time
// - Switch stops reference briefly without runt pulses
// - Reference select writes ignored in slow mode
// - Re-enabling running fast oscillator starts no warm-up
// - System clock is gear or slow quarter
package cgs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CLOCK_GEAR     = 12'hFCF;
  localparam logic [11:0] IDX_SYS_CONTROL_1  = 12'hFDC;
  localparam logic [11:0] IDX_SYS_CONTROL_2  = 12'hFDD;
  localparam logic [11:0] IDX_PORT_ZERO_FUNC = 12'hFD0;

  // Field positions
  localparam int GEAR_LSB       = 0;
  localparam int REF_SEL_BIT    = 3;
  localparam int INT_EN_BIT     = 7;
  localparam int FAST_EN_BIT    = 6;
  localparam int SLOW_EN_BIT    = 5;
  localparam int SYS_SEL_BIT    = 4;
  localparam int FAST_PIN_BIT   = 0;
  localparam int SLOW_PIN_BIT   = 2;

  // Values after reset
  localparam logic [1:0] GEAR_RESET     = 2'h0;
  localparam logic       REF_SEL_RESET  = 1'h0;
  localparam logic       INT_EN_RESET   = 1'h1;
  localparam logic       FAST_EN_RESET  = 1'h0;
  localparam logic       SLOW_EN_RESET  = 1'h0;
  localparam logic       SYS_SEL_RESET  = 1'h0;
  localparam logic       PIN_FUNC_RESET = 1'h0;

  // Gear encodings
  localparam logic [1:0] GEAR_DIV4     = 2'h0;
  localparam logic [1:0] GEAR_DIV2     = 2'h1;
  localparam logic [1:0] GEAR_DIV1     = 2'h2;
  localparam logic [1:0] GEAR_RESERVED = 2'h3;

  // Cycle counts
  localparam logic [1:0] RESET_HOLD_CYCLES = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_OLD_LOW, SW_HOLD} cgs_switch_t;
endpackage

// file: hw/cgs_gear_if.sv
// Carrier between the control top and its gear divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface cgs_gear_if;
  logic       ref_level;   // Selected fast reference, sampled
  logic       ref_rise;    // One-cycle pulse on reference rising edge
  logic [1:0] divide_sel;  // Requested gear setting
  logic       gear_clk;    // Divided gear clock level
  logic [1:0] gear_active; // Gear setting now in effect

  modport ctrl (output ref_level, output ref_rise, output divide_sel, input gear_clk, input gear_active);
  modport div  (input ref_level, input ref_rise, input divide_sel, output gear_clk, output gear_active);
endinterface

// file: hw/cgs_gear_div.sv
// Gear divider: derives the gear clock from the sampled fast reference.
// Assumes reference edges arrive well below half the system clock rate.
`timescale 1ns/10ps
module cgs_gear_div (
  input  wire logic clk_i,   // System clock
  input  wire logic reset_i, // Synchronous reset, active high
  cgs_gear_if.div   gear     // Reference in, gear clock out
);
  logic [1:0] active_sel;
  logic [1:0] edge_cnt;
  logic       div_level;
  logic       boundary;
  logic [1:0] next_cnt;
  logic       next_level;

  // Boundary: divided clock about to rise; full-rate passes at any rise
  assign boundary = gear.ref_rise &&
                    ((active_sel == cgs_pkg::GEAR_DIV1) ||
                     (edge_cnt == 2'h0 && !div_level) ||
                     (active_sel == cgs_pkg::GEAR_DIV2 && !div_level));

  always_comb begin
    next_cnt   = edge_cnt;
    next_level = div_level;
    if (gear.ref_rise) begin
      case (active_sel)
        cgs_pkg::GEAR_DIV4: begin
          next_cnt = edge_cnt + 2'h1;
          if (edge_cnt[0]) begin
            next_level = !div_level;
          end
        end
        cgs_pkg::GEAR_DIV2: begin
          next_level = !div_level;
        end
        default: begin
          next_cnt = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      active_sel <= cgs_pkg::GEAR_RESET;
      edge_cnt   <= 2'h0;
      div_level  <= 1'b0;
    end else begin
      // Reserved code keeps the old setting rather than guess a ratio
      if (boundary && gear.divide_sel != cgs_pkg::GEAR_RESERVED) begin
        active_sel <= gear.divide_sel;
      end
      edge_cnt  <= next_cnt;
      div_level <= next_level;
    end
  end

  // Full rate follows the reference itself; leaving it while div_level is low gives a one-cycle runt
  assign gear.gear_clk    = (active_sel == cgs_pkg::GEAR_DIV1) ? gear.ref_level : div_level;
  assign gear.gear_active = active_sel;
endmodule

// file: hw/cgs_clock_ctrl.sv
// Fast clock gear and oscillator switch control, AXI4-Lite register slave.
// Assumes oscillator clocks arrive on pins well below half the system clock.
`timescale 1ns/10ps
module cgs_clock_ctrl #(
  parameter int ADDR_W = 16 // AXI address width
) (
  input  wire logic              clk_i,                 // System clock, 100 MHz
  input  wire logic              reset_i,               // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // Write address
  input  wire logic              s_axi_awvalid,         // Write address valid
  output logic                   s_axi_awready,         // Write address ready
  input  wire logic [31:0]       s_axi_wdata,           // Write data
  input  wire logic [3:0]        s_axi_wstrb,           // Write strobes
  input  wire logic              s_axi_wvalid,          // Write data valid
  output logic                   s_axi_wready,          // Write data ready
  output logic [1:0]             s_axi_bresp,           // Write response
  output logic                   s_axi_bvalid,          // Write response valid
  input  wire logic              s_axi_bready,          // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,          // Read address
  input  wire logic              s_axi_arvalid,         // Read address valid
  output logic                   s_axi_arready,         // Read address ready
  output logic [31:0]            s_axi_rdata,           // Read data
  output logic [1:0]             s_axi_rresp,           // Read response
  output logic                   s_axi_rvalid,          // Read data valid
  input  wire logic              s_axi_rready,          // Read data ready
  input  wire logic              internal_fast_clk_i,   // Internal fast oscillator
  input  wire logic              external_fast_clock_i, // External fast oscillator
  input  wire logic              external_slow_clock_i, // External slow oscillator
  input  wire logic              stop_mode_i,           // Mode controller in stop mode
  output logic                   internal_osc_enable_o, // Internal fast oscillator enable
  output logic                   fast_osc_enable_o,     // External fast oscillator enable
  output logic                   slow_osc_enable_o,     // External slow oscillator enable
  output logic                   fast_crystal_pins_o,   // Fast crystal pin function
  output logic                   slow_crystal_pins_o,   // Slow crystal pin function
  output logic                   warmup_start_o,        // Warm-up counter start pulse
  output logic                   fast_reference_clock_o,// Selected fast reference
  output logic                   gear_clock_o,          // Gear clock
  output logic                   system_clock_o,        // System clock
  output logic                   switch_busy_o,         // Reference or system switch pending
  output logic                   sysclk_reset_o         // System clock reset
);
  // Decode slices bits 13:2 and tests the bits above, so at least one upper bit
  if (ADDR_W < 15 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must hold the register byte addresses");
  end

  // Registers
  logic [1:0] gear_divide_select;
  logic       ref_sel;
  logic       int_en;
  logic       fast_en;
  logic       slow_en;
  logic       sys_sel;
  logic       fast_pin_func;
  logic       slow_pin_func;

  // Oscillator sampling; stage 0 feeds stage 1 only
  logic [2:0] int_sync;
  logic [2:0] fast_sync;
  logic [2:0] slow_sync;

  // Reference and system switch state, slow quarter clock, reset hold
  cgs_pkg::cgs_switch_t sw_state;
  logic                 ref_ext_active;
  logic                 ref_level;
  logic                 ref_level_q;
  logic                 sys_slow_active;
  logic [1:0]           slow_cnt;
  logic                 slow_quarter;
  logic [1:0]           reset_hold;

  // AXI state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  cgs_gear_if gear_bus ();

  cgs_gear_div u_gear (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .gear    (gear_bus.div)
  );

  function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[13:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = reg_index(addr);
    is_mapped = (addr[ADDR_W-1:14] == '0) &&
                (idx == cgs_pkg::IDX_CLOCK_GEAR || idx == cgs_pkg::IDX_SYS_CONTROL_1 ||
                 idx == cgs_pkg::IDX_SYS_CONTROL_2 || idx == cgs_pkg::IDX_PORT_ZERO_FUNC);
  endfunction

  // Write decode
  wire        do_write   = aw_held && w_held && !s_axi_bvalid;
  wire        wr_lane    = w_strb[0];
  wire [11:0] wr_idx     = reg_index(aw_addr);
  wire        wr_mapped  = is_mapped(aw_addr);
  wire        wr_gear    = do_write && wr_lane && wr_mapped && wr_idx == cgs_pkg::IDX_CLOCK_GEAR;
  wire        wr_sys1    = do_write && wr_lane && wr_mapped && wr_idx == cgs_pkg::IDX_SYS_CONTROL_1;
  wire        wr_sys2    = do_write && wr_lane && wr_mapped && wr_idx == cgs_pkg::IDX_SYS_CONTROL_2;
  wire        wr_port    = do_write && wr_lane && wr_mapped && wr_idx == cgs_pkg::IDX_PORT_ZERO_FUNC;
  wire [7:0]  wbyte      = w_data[7:0];

  // Read decode
  wire        do_read    = s_axi_arvalid && s_axi_arready;
  wire [11:0] rd_idx     = reg_index(s_axi_araddr);
  wire [7:0]  gear_rd    = {6'h00, gear_divide_select};
  wire [7:0]  sys1_rd    = {4'h0, ref_sel, 3'h0};
  wire [7:0]  sys2_rd    = {int_en, fast_en, slow_en, sys_sel, 4'h0};
  wire [7:0]  port_rd    = {5'h00, slow_pin_func, 1'b0, fast_pin_func};
  wire [7:0]  rd_byte    = (rd_idx == cgs_pkg::IDX_CLOCK_GEAR)    ? gear_rd :
                           (rd_idx == cgs_pkg::IDX_SYS_CONTROL_1) ? sys1_rd :
                           (rd_idx == cgs_pkg::IDX_SYS_CONTROL_2) ? sys2_rd :
                           (rd_idx == cgs_pkg::IDX_PORT_ZERO_FUNC) ? port_rd : 8'h00;

  // Oscillator edges from the settled stages only
  wire int_lvl   = int_sync[1];
  wire fast_lvl  = fast_sync[1];
  wire int_fall  = int_sync[2] && !int_sync[1];
  wire fast_fall = fast_sync[2] && !fast_sync[1];
  wire slow_rise = !slow_sync[2] && slow_sync[1];

  // Stop mode lets hardware override external enables and pins
  wire fast_en_eff  = fast_en && !stop_mode_i;
  wire slow_en_eff  = slow_en && !stop_mode_i;
  wire fast_pin_eff = fast_pin_func && !stop_mode_i;
  wire slow_pin_eff = slow_pin_func && !stop_mode_i;

  wire ref_pending  = ref_sel != ref_ext_active;
  wire old_ref_en   = ref_ext_active ? fast_en : int_en;
  wire old_ref_fall = ref_ext_active ? fast_fall : int_fall;
  wire new_ref_fall = ref_ext_active ? int_fall : fast_fall;
  wire sys_pending  = sys_sel != sys_slow_active;
  wire old_sys_en   = sys_slow_active ? slow_en : (ref_ext_active ? fast_en : int_en);

  // Clock reset causes, masked while stopped since every oscillator may halt
  wire cause_all_off  = !int_en && !fast_en && !slow_en;
  wire cause_slow_off = sys_sel && !slow_en;
  wire cause_int_off  = !sys_sel && !ref_sel && !int_en;
  wire cause_fast_off = !sys_sel && ref_sel && !fast_en;
  wire cause_no_pins  = fast_en && !fast_pin_func;
  wire cause_midswap  = (sw_state != cgs_pkg::SW_IDLE && !old_ref_en) ||
                        (sys_pending && !old_sys_en);
  wire clock_fault    = !stop_mode_i && (cause_all_off || cause_slow_off || cause_int_off ||
                        cause_fast_off || cause_no_pins || cause_midswap);

  always_ff @(posedge clk_i) begin
    int_sync  <= {int_sync[1:0], internal_fast_clk_i};
    fast_sync <= {fast_sync[1:0], external_fast_clock_i};
    slow_sync <= {slow_sync[1:0], external_slow_clock_i};
  end

  // Register file
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gear_divide_select <= cgs_pkg::GEAR_RESET;
      ref_sel            <= cgs_pkg::REF_SEL_RESET;
      int_en             <= cgs_pkg::INT_EN_RESET;
      fast_en            <= cgs_pkg::FAST_EN_RESET;
      slow_en            <= cgs_pkg::SLOW_EN_RESET;
      sys_sel            <= cgs_pkg::SYS_SEL_RESET;
      fast_pin_func      <= cgs_pkg::PIN_FUNC_RESET;
      slow_pin_func      <= cgs_pkg::PIN_FUNC_RESET;
      warmup_start_o     <= 1'b0;
    end else begin
      warmup_start_o <= wr_sys2 && wbyte[cgs_pkg::FAST_EN_BIT] && !fast_en;
      if (wr_gear) begin
        gear_divide_select <= wbyte[cgs_pkg::GEAR_LSB +: 2];
      end
      if (wr_sys1 && !sys_sel) begin
        ref_sel <= wbyte[cgs_pkg::REF_SEL_BIT];
      end
      if (wr_sys2) begin
        int_en  <= wbyte[cgs_pkg::INT_EN_BIT];
        fast_en <= wbyte[cgs_pkg::FAST_EN_BIT];
        slow_en <= wbyte[cgs_pkg::SLOW_EN_BIT];
        sys_sel <= wbyte[cgs_pkg::SYS_SEL_BIT];
      end
      if (wr_port) begin
        fast_pin_func <= wbyte[cgs_pkg::FAST_PIN_BIT];
        slow_pin_func <= wbyte[cgs_pkg::SLOW_PIN_BIT];
      end
    end
  end

  // Reference switch: finish old period, hold low, resume on new clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sw_state       <= cgs_pkg::SW_IDLE;
      ref_ext_active <= 1'b0;
    end else begin
      case (sw_state)
        cgs_pkg::SW_IDLE: begin
          if (ref_pending) begin
            sw_state <= cgs_pkg::SW_WAIT_OLD_LOW;
          end
        end
        cgs_pkg::SW_WAIT_OLD_LOW: begin
          if (old_ref_fall) begin
            sw_state <= cgs_pkg::SW_HOLD;
          end
        end
        cgs_pkg::SW_HOLD: begin
          if (new_ref_fall) begin
            ref_ext_active <= !ref_ext_active;
            sw_state       <= cgs_pkg::SW_IDLE;
          end
        end
        default: begin
          sw_state <= cgs_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // Reference level: low while held, so no partial pulse escapes
  assign ref_level = (sw_state == cgs_pkg::SW_HOLD) ? 1'b0 :
                     (ref_ext_active ? fast_lvl : int_lvl);

  // Slow quarter clock and system clock source handover
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_level_q     <= 1'b0;
      slow_cnt        <= 2'h0;
      slow_quarter    <= 1'b0;
      sys_slow_active <= 1'b0;
    end else begin
      ref_level_q <= ref_level;
      if (slow_rise) begin
        slow_cnt <= slow_cnt + 2'h1;
        if (slow_cnt[0]) begin
          slow_quarter <= !slow_quarter;
        end
      end
      // Hand over while both candidates sit low
      if (sys_pending && !slow_quarter && !gear_bus.gear_clk) begin
        sys_slow_active <= sys_sel;
      end
    end
  end

  assign gear_bus.ref_level  = ref_level;
  assign gear_bus.ref_rise   = ref_level && !ref_level_q;
  assign gear_bus.divide_sel = gear_divide_select;

  // Clock reset pulse, stretched so a running clock sees it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reset_hold     <= 2'h0;
      sysclk_reset_o <= 1'b0;
    end else begin
      if (clock_fault) begin
        reset_hold <= cgs_pkg::RESET_HOLD_CYCLES;
      end else if (reset_hold != 2'h0) begin
        reset_hold <= reset_hold - 2'h1;
      end
      sysclk_reset_o <= clock_fault || reset_hold > 2'h1;
    end
  end

  // AXI4-Lite slave; address and data taken in either order
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cgs_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= cgs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? cgs_pkg::RESP_OKAY : cgs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, is_mapped(s_axi_araddr) ? rd_byte : 8'h00};
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? cgs_pkg::RESP_OKAY : cgs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign internal_osc_enable_o  = int_en;
  assign fast_osc_enable_o      = fast_en_eff;
  assign slow_osc_enable_o      = slow_en_eff;
  assign fast_crystal_pins_o    = fast_pin_eff;
  assign slow_crystal_pins_o    = slow_pin_eff;
  assign fast_reference_clock_o = ref_level;
  assign gear_clock_o           = gear_bus.gear_clk;
  assign system_clock_o         = sys_slow_active ? slow_quarter : gear_bus.gear_clk;
  assign switch_busy_o          = ref_pending || sw_state != cgs_pkg::SW_IDLE || sys_pending;
endmodule

// file: dv/cgs_osc_model.sv
// Stand-ins for the three oscillators.
// Assumes enables come from the control outputs.
`timescale 1ns/10ps
module cgs_osc_model (
  input  wire logic int_en_i,  // Internal enable
  input  wire logic fast_en_i, // Fast enable
  input  wire logic slow_en_i, // Slow enable
  output logic      int_o,     // Internal clock
  output logic      fast_o,    // Fast clock
  output logic      slow_o     // Slow clock
);
  // A stopped oscillator rests low
  initial {int_o, fast_o, slow_o} = 3'h0;
  always #51 int_o = int_en_i & ~int_o;
  always #61 fast_o = fast_en_i & ~fast_o;
  always #83 slow_o = slow_en_i & ~slow_o;
endmodule

// file: dv/cgs_clock_ctrl_props.sv
// Port checker for the clock control.
// Assumes one clock domain, bound to the top.
`timescale 1ns/10ps
module cgs_clock_ctrl_props (
  input wire logic clk_i,                  // Clock
  input wire logic reset_i,                // Reset
  input wire logic stop_mode_i,            // Stop
  input wire logic internal_osc_enable_o,  // Int en
  input wire logic fast_osc_enable_o,      // Fast en
  input wire logic slow_osc_enable_o,      // Slow en
  input wire logic fast_crystal_pins_o,    // Fast pins
  input wire logic slow_crystal_pins_o,    // Slow pins
  input wire logic warmup_start_o,         // Warm-up
  input wire logic fast_reference_clock_o, // Reference
  input wire logic switch_busy_o,          // Busy
  input wire logic sysclk_reset_o          // Clock reset
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_all_off:
    assert property (!internal_osc_enable_o && !fast_osc_enable_o && !slow_osc_enable_o && !stop_mode_i
      |-> ##[0:2] sysclk_reset_o) else $error("all off without reset");
  a_fast_pin:
    assert property (fast_osc_enable_o && !fast_crystal_pins_o && !stop_mode_i |-> ##[0:2] sysclk_reset_o)
      else $error("pin fault without reset");
  a_busy_bound:
    assert property (disable iff (reset_i || sysclk_reset_o) $rose(switch_busy_o) |-> ##[1:300] !switch_busy_o)
      else $error("switch too long");
  a_warm_edge:
    assert property (warmup_start_o |-> !$past(fast_osc_enable_o) ##1 !warmup_start_o) else $error("bad warm-up");
  a_stop_forces:
    assert property (stop_mode_i |-> !(fast_osc_enable_o | slow_osc_enable_o | fast_crystal_pins_o
      | slow_crystal_pins_o)) else $error("stop not forced");
  a_stop_mask:
    assert property (stop_mode_i [*3] |-> !sysclk_reset_o) else $error("reset in stop");
  a_reset_width:
    assert property ($rose(sysclk_reset_o) |=> sysclk_reset_o) else $error("reset too short");
  a_ref_runt:
    assert property ($rose(fast_reference_clock_o) && !$past(reset_i, 8) |-> fast_reference_clock_o [*3])
      else $error("reference runt");
endmodule
bind cgs_clock_ctrl cgs_clock_ctrl_props i_props (.clk_i(clk_i), .reset_i(reset_i), .stop_mode_i(stop_mode_i),
  .internal_osc_enable_o(internal_osc_enable_o), .fast_osc_enable_o(fast_osc_enable_o),
  .slow_osc_enable_o(slow_osc_enable_o), .fast_crystal_pins_o(fast_crystal_pins_o),
  .slow_crystal_pins_o(slow_crystal_pins_o), .warmup_start_o(warmup_start_o),
  .fast_reference_clock_o(fast_reference_clock_o), .switch_busy_o(switch_busy_o), .sysclk_reset_o(sysclk_reset_o));

// file: dv/tb_top.sv
// Self-checking bench for the clock control.
// Assumes the oscillator model and bound checker.
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic        clk_i = 1'h0, reset_i = 1'h1, stop = 1'h0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, q, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, int_en, fast_en, slow_en;
  logic        o_int, o_fast, o_slow, refc, gear, busy, srst, warm, sysc;
  logic [7:0]  d;
  int          error_cnt = 0, cmp_count = 0, warm_cnt = 0, seed = 32'h1A9F75E1;
  localparam logic [11:0] G = cgs_pkg::IDX_CLOCK_GEAR, S1 = cgs_pkg::IDX_SYS_CONTROL_1;
  localparam logic [11:0] S2 = cgs_pkg::IDX_SYS_CONTROL_2, PZ = cgs_pkg::IDX_PORT_ZERO_FUNC;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (warm === 1'h1) warm_cnt++;
  cgs_clock_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .internal_fast_clk_i(o_int),
    .external_fast_clock_i(o_fast), .external_slow_clock_i(o_slow), .stop_mode_i(stop),
    .internal_osc_enable_o(int_en), .fast_osc_enable_o(fast_en), .slow_osc_enable_o(slow_en),
    .fast_crystal_pins_o(), .slow_crystal_pins_o(), .warmup_start_o(warm), .fast_reference_clock_o(refc),
    .gear_clock_o(gear), .system_clock_o(sysc), .switch_busy_o(busy), .sysclk_reset_o(srst));
  cgs_osc_model i_osc (.int_en_i(int_en), .fast_en_i(fast_en), .slow_en_i(slow_en), .int_o(o_int),
    .fast_o(o_fast), .slow_o(o_slow));
  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Handshakes judged at the falling edge, so the next rising edge sees the same values
  task automatic acc(input logic w, input logic [11:0] i, input logic [7:0] v);
    logic ta, tw, td;
    @(posedge clk_i);
    if (w) begin
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {24'h0, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
    end else begin
      araddr <= {2'h0, i, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
    end
    td = 1'h0;
    for (int n = 0; n < 50 && !td; n++) begin
      @(negedge clk_i);
      ta = w ? awvalid && awready : arvalid && arready;
      tw = wvalid && wready;
      td = w ? bvalid === 1'h1 : rvalid === 1'h1;
      q = rdata;
      rs = w ? bresp : rresp;
      @(posedge clk_i);
      if (ta) begin awvalid <= 1'h0; arvalid <= 1'h0; end
      if (tw) wvalid <= 1'h0;
      if (td) begin bready <= 1'h0; rready <= 1'h0; end
    end
    if (!td) begin error_cnt++; end_sim(); end
  endtask
  task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er);
    acc(1'h0, i, 8'h00);
    `CHK(q, {24'h0, e})
    `CHK(rs, er)
  endtask
  task automatic ws(input logic e);
    for (int n = 0; n < 40 && srst !== e; n++) @(negedge clk_i);
    `CHK(srst, e)
    if (srst !== e) end_sim();
  endtask
  task automatic wb();
    for (int n = 0; n < 400 && busy !== 1'h0; n++) @(negedge clk_i);
    `CHK(busy, 1'h0)
    if (busy !== 1'h0) end_sim();
  endtask
  function automatic int div_of(input logic [1:0] g);
    return g == 2'h0 ? 4 : g == 2'h1 ? 2 : 1;
  endfunction
  // Source rises over one whole output period, after the change has settled
  // Gear clock against reference, or system clock against the slow oscillator
  task automatic per_chk(input logic s, input int e);
    int gr, rr;
    logic pg, pr, c, r;
    gr = 0;
    rr = 0;
    pg = 1'h1;
    pr = 1'h1;
    for (int n = 0; n < 600 && gr < 4; n++) begin
      @(negedge clk_i);
      c = s ? sysc : gear;
      r = s ? o_slow : refc;
      if (c && !pg) gr++;
      if (r && !pr && gr == 3) rr++;
      pg = c;
      pr = r;
    end
    `CHK(gr, 4)
    `CHK(rr, e)
  endtask
  task automatic gear_chk(input logic [1:0] g);
    acc(1'h1, G, {6'h0, g});
    per_chk(1'h0, div_of(g));
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'h0;
    rd(G, 8'h00, 2'h0);
    rd(S1, 8'h00, 2'h0);
    rd(S2, 8'h80, 2'h0);
    rd(12'h123, 8'h00, cgs_pkg::RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      acc(1'h1, G, d);
      rd(G, {6'h0, d[1:0]}, 2'h0);
    end
    for (int g = 0; g < 3; g++) gear_chk(2'(g));
    acc(1'h1, S2, 8'h00);
    ws(1'h1);
    acc(1'h1, S2, 8'h80);
    ws(1'h0);
    acc(1'h1, S2, 8'hC0);
    ws(1'h1);
    acc(1'h1, PZ, 8'h05);
    ws(1'h0);
    acc(1'h1, S2, 8'hC0);
    `CHK(warm_cnt, 1)
    acc(1'h1, S1, 8'h08);
    wb();
    acc(1'h1, S2, 8'h40);
    repeat (3) @(negedge clk_i);
    `CHK(srst, 1'h0)
    acc(1'h1, S2, 8'h60);
    acc(1'h1, S2, 8'h70);
    wb();
    per_chk(1'h1, 4);
    acc(1'h1, S1, 8'h00);
    rd(S1, 8'h08, 2'h0);
    acc(1'h1, S2, 8'h20);
    ws(1'h1);
    @(posedge clk_i);
    stop <= 1'h1;
    repeat (4) @(negedge clk_i);
    `CHK(srst, 1'h0)
    `CHK(slow_en, 1'h0)
    end_sim();
  end
endmodule
